//--- hdl/lsil_top.sv
// Front-panel lamp logic with pattern-test timer, strap capture and register port.
`timescale 1ns/10ps
// What this block does
// - Span link lamp is solid green while the framer link is up, else off.
// - Transmit and receive lamps show yellow for a one, green for a zero.
// - No-signal lamp is red while not connected to the remote unit.
// - Fault lamp blinks continuously after a pattern test has timed out.
// - Fault lamp pulses once per CRC error outside pattern tests, or per bit error during them.
// - During power-up an unsupported rate blinks the fault lamp every 200 ms.
// - Test lamp is yellow while a local or remote test mode is active, except while a management flash inverts it.
// - Each valid management packet flashes the test lamp for 400 ms.
// - Serial port is DCE by default; the strap selects the DTE role.
// - A running pattern generator stops itself after 45 seconds.
// - Timeout blinking lasts until the pattern selection returns to normal.
module lsil_top
  import lsil_pkg::*;
#(
  parameter lsil_cnt_t PG_CYC    = lsil_cnt_t'(PG_TIMEOUT_CYC),
  parameter lsil_cnt_t BLINK_CYC = lsil_cnt_t'(RATE_BLINK_CYC),
  parameter lsil_cnt_t FLASH_CYC = lsil_cnt_t'(MGMT_FLASH_CYC),
  parameter lsil_cnt_t PULSE_CYC = lsil_cnt_t'(ERR_PULSE_CYC)
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              span_link_up_i,
  input  wire logic              tx_data_i,
  input  wire logic              rx_data_i,
  input  wire logic              connected_i,
  input  wire logic              local_test_i,
  input  wire logic              remote_test_i,
  input  wire logic              pattern_sel_i,
  input  wire logic              crc_err_i,
  input  wire logic              bit_err_i,
  input  wire logic              rate_unsupported_i,
  input  wire logic              mgmt_pkt_i,
  input  wire logic              dte_strap_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output lsil_lamps_s            lamps_o,
  output logic                   pattern_gen_on_o,
  output logic                   dte_role_o,
  output logic                   irq_o
);

  // Whole state of the block in one record.
  typedef struct packed {
    lsil_pg_e    pg;
    lsil_cnt_t   pg_timer;
    lsil_cnt_t   blink_cnt;
    lsil_cnt_t   pulse_cnt;
    lsil_cnt_t   flash_cnt;
    logic        powerup;
    logic        strap_taken;
    logic        dte_role;
    logic        pattern_on;
    logic [1:0]  ctrl;
    logic [4:0]  status;
    logic [4:0]  mask;
    logic        irq;
    logic [31:0] rd_data;
    lsil_lamps_s lamps;
  } lsil_state_s;

  localparam lsil_state_s ST_RESET = '{
    pg:          PG_IDLE,
    pg_timer:    32'h0,
    blink_cnt:   32'h0,
    pulse_cnt:   32'h0,
    flash_cnt:   32'h0,
    powerup:     1'b1,
    strap_taken: 1'b0,
    dte_role:    1'b0,
    pattern_on:  1'b0,
    ctrl:        CTRL_RESET,
    status:      5'h00,
    mask:        MASK_RESET,
    irq:         1'b0,
    rd_data:     32'h0,
    lamps:       '{LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF}
  };

  lsil_state_s st;
  lsil_state_s next_st;
  logic [4:0]  ev;
  logic [4:0]  w1c;
  logic        blink_on;
  logic        timeout_blink;
  logic        rate_blink;
  logic        cont_blink;
  logic        pulse_ev;
  logic        test_on;

  // Counts a timer down to zero and holds it there.
  function automatic lsil_cnt_t dec_sat(input lsil_cnt_t c);
    dec_sat = (c == 32'h0) ? 32'h0 : c - 32'h1;
  endfunction

  // Colour for a data line: an idle one shows yellow, a zero green.
  function automatic lsil_lamp_e line_colour(input logic bit_val);
    line_colour = bit_val ? LAMP_YELLOW : LAMP_GREEN;
  endfunction

  // Next-state logic for every part of the block.
  always_comb begin
    next_st       = st;
    ev            = 5'h00;
    w1c           = 5'h00;
    next_st.rd_data = 32'h0;

    // The strap is caught once, on the first edge after reset release.
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.dte_role    = dte_strap_i;
    end

    // Power-up ends when the span link first comes up.
    if (span_link_up_i) begin
      next_st.powerup = 1'b0;
    end

    // Free-running blink timebase; lamp lit in the first half of each period.
    next_st.blink_cnt = (st.blink_cnt >= BLINK_CYC - 32'h1) ? 32'h0 : st.blink_cnt + 32'h1;
    blink_on          = st.blink_cnt < (BLINK_CYC >> 1);

    // Pattern generator: runs while selected, stops itself at the timeout.
    case (st.pg)
      PG_IDLE: begin
        if (pattern_sel_i) begin
          next_st.pg       = PG_RUN;
          next_st.pg_timer = 32'h0;
        end
      end
      PG_RUN: begin
        if (!pattern_sel_i) begin
          next_st.pg = PG_IDLE;
        end else if (st.pg_timer >= PG_CYC - 32'h1) begin
          next_st.pg        = PG_TIMED_OUT;
          ev[EV_PG_TIMEOUT] = 1'b1;
        end else begin
          next_st.pg_timer = st.pg_timer + 32'h1;
        end
      end
      PG_TIMED_OUT: begin
        if (!pattern_sel_i) begin
          next_st.pg = PG_IDLE;
        end
      end
      default: begin
        next_st.pg = PG_IDLE;
      end
    endcase
    next_st.pattern_on = (next_st.pg == PG_RUN);

    // Continuous patterns take priority over single pulses.
    timeout_blink = (st.pg == PG_TIMED_OUT);
    rate_blink    = st.powerup && rate_unsupported_i;
    cont_blink    = timeout_blink || rate_blink;

    // CRC errors count in normal operation, bit errors only during a test.
    ev[EV_CRC]      = crc_err_i && !st.pattern_on;
    ev[EV_BIT_ERR]  = bit_err_i && st.pattern_on;
    ev[EV_MGMT_PKT] = mgmt_pkt_i;
    ev[EV_RATE_ERR] = rate_blink;
    pulse_ev        = ev[EV_CRC] || ev[EV_BIT_ERR];

    // A new error restarts the pulse; masked while a continuous blink runs.
    if (cont_blink) begin
      next_st.pulse_cnt = 32'h0;
    end else if (pulse_ev && st.ctrl[CTRL_PULSE_EN]) begin
      next_st.pulse_cnt = PULSE_CYC;
    end else begin
      next_st.pulse_cnt = dec_sat(st.pulse_cnt);
    end

    // Each valid management packet restarts the test lamp flash.
    if (mgmt_pkt_i) begin
      next_st.flash_cnt = FLASH_CYC;
    end else begin
      next_st.flash_cnt = dec_sat(st.flash_cnt);
    end

    // Lamp colours, registered so the panel never sees a glitch.
    test_on = local_test_i || remote_test_i;
    next_st.lamps.span_link_lamp     = span_link_up_i ? LAMP_GREEN : LAMP_OFF;
    next_st.lamps.transmit_line_lamp = line_colour(tx_data_i);
    next_st.lamps.receive_line_lamp  = line_colour(rx_data_i);
    next_st.lamps.no_signal_lamp     = connected_i ? LAMP_OFF : LAMP_RED;
    if (cont_blink) begin
      next_st.lamps.fault_lamp = blink_on ? LAMP_RED : LAMP_OFF;
    end else begin
      next_st.lamps.fault_lamp = (st.pulse_cnt != 32'h0) ? LAMP_RED : LAMP_OFF;
    end
    // The flash inverts the test lamp so it shows whether or not a test runs.
    next_st.lamps.test_lamp = (test_on ^ (st.flash_cnt != 32'h0)) ? LAMP_YELLOW : LAMP_OFF;
    if (st.ctrl[CTRL_LAMP_OFF]) begin
      next_st.lamps = '{LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF, LAMP_OFF};
    end

    // Register writes; unmapped addresses are ignored.
    if (reg_wr_i) begin
      if (reg_addr_i == REG_CTRL) begin
        next_st.ctrl = reg_wdata_i[1:0];
      end else if (reg_addr_i == REG_IRQ_STAT) begin
        w1c = reg_wdata_i[EV_W-1:0];
      end else if (reg_addr_i == REG_IRQ_MASK) begin
        next_st.mask = reg_wdata_i[EV_W-1:0];
      end
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    if (reg_rd_i) begin
      if (reg_addr_i == REG_CTRL) begin
        next_st.rd_data = {30'h0, st.ctrl};
      end else if (reg_addr_i == REG_IRQ_STAT) begin
        next_st.rd_data = {27'h0, st.status};
      end else if (reg_addr_i == REG_IRQ_MASK) begin
        next_st.rd_data = {27'h0, st.mask};
      end else if (reg_addr_i == REG_LAMPS) begin
        next_st.rd_data = {12'h0, st.powerup, st.dte_role, st.pg, st.pattern_on,
                           2'h0, st.lamps};
      end
    end

    // An event in the clearing cycle survives: set wins over clear.
    next_st.status = (st.status & ~w1c) | ev;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state record.
  assign reg_rdata_o      = st.rd_data;
  assign lamps_o          = st.lamps;
  assign pattern_gen_on_o = st.pattern_on;
  assign dte_role_o       = st.dte_role;
  assign irq_o            = st.irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Timeout step followed by the generator turning off and blinking starting.
  sequence s_pg_expire;
    st.pg == PG_RUN && pattern_sel_i && st.pg_timer >= PG_CYC - 32'h1;
  endsequence
  sequence s_pg_stopped;
    !pattern_gen_on_o && st.pg == PG_TIMED_OUT && st.status[EV_PG_TIMEOUT];
  endsequence

  chk_span_lamp_follow: assert property (
    !st.ctrl[CTRL_LAMP_OFF] ##0 1 |=> (lamps_o.span_link_lamp ==
      ($past(span_link_up_i) ? LAMP_GREEN : LAMP_OFF)))
    else $error("span link lamp does not follow the link state");

  chk_tx_line_colour: assert property (
    !st.ctrl[CTRL_LAMP_OFF] && !tx_data_i |=> lamps_o.transmit_line_lamp == LAMP_GREEN)
    else $error("transmit line lamp not green for a zero");

  chk_no_signal_red: assert property (
    !st.ctrl[CTRL_LAMP_OFF] && !connected_i |=> lamps_o.no_signal_lamp == LAMP_RED)
    else $error("no-signal lamp not red while disconnected");

  chk_pg_timeout_stop: assert property (
    s_pg_expire |=> s_pg_stopped)
    else $error("pattern generator did not stop at timeout");

  chk_timeout_blink_end: assert property (
    st.pg == PG_TIMED_OUT && !pattern_sel_i |=> st.pg == PG_IDLE ##1 !timeout_blink)
    else $error("timeout blinking did not end on deselect");

  chk_crc_pulse_start: assert property (
    crc_err_i && !st.pattern_on && !cont_blink && st.ctrl[CTRL_PULSE_EN]
      |=> st.pulse_cnt == PULSE_CYC ##1 (st.lamps.fault_lamp == LAMP_RED
      || $past(st.ctrl[CTRL_LAMP_OFF]) || $past(cont_blink)))
    else $error("CRC error did not start a fault pulse");

  chk_rate_blink_gate: assert property (
    !st.powerup && !st.status[EV_RATE_ERR] |=> !st.status[EV_RATE_ERR])
    else $error("rate error flagged outside power-up");

  chk_pulse_masked: assert property (
    cont_blink |=> st.pulse_cnt == 32'h0)
    else $error("error pulse not masked during continuous blink");

  chk_test_lamp_on: assert property (
    (local_test_i || remote_test_i) && st.flash_cnt == 32'h0 && !st.ctrl[CTRL_LAMP_OFF]
      |=> lamps_o.test_lamp == LAMP_YELLOW)
    else $error("test lamp not yellow in test mode");

  chk_mgmt_flash_len: assert property (
    mgmt_pkt_i ##1 !mgmt_pkt_i
      |-> st.flash_cnt == FLASH_CYC ##1 st.flash_cnt == FLASH_CYC - 32'h1)
    else $error("management flash length wrong");

  chk_strap_held: assert property (
    st.strap_taken |=> $stable(dte_role_o))
    else $error("port role changed after strap capture");

  // The first cycle of each blink period must reach the panel lit after a timeout.
  chk_timeout_blink_run: assert property (
    st.pg == PG_TIMED_OUT && st.blink_cnt == 32'h0 && !st.ctrl[CTRL_LAMP_OFF]
      |=> lamps_o.fault_lamp == LAMP_RED)
    else $error("timeout blink not lit at the start of its period");

  // An idle receive line shows yellow.
  chk_rx_line_colour: assert property (
    !st.ctrl[CTRL_LAMP_OFF] && rx_data_i |=> lamps_o.receive_line_lamp == LAMP_YELLOW)
    else $error("receive line lamp not yellow for a one");

  // Once connected the no-signal lamp goes dark, whatever the control bits say.
  chk_no_signal_off: assert property (
    connected_i |=> lamps_o.no_signal_lamp == LAMP_OFF)
    else $error("no-signal lamp lit while connected");

  // A CRC event in the clearing cycle must still leave its status bit set.
  chk_set_beats_clear: assert property (
    crc_err_i && !st.pattern_on |=> st.status[EV_CRC])
    else $error("CRC status bit lost");

  // Read data stand only in the cycle after a read strobe and are zero otherwise.
  chk_rdata_idle_zero: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data present without a read");

  // Lamps-off control darkens the whole panel on the next edge.
  chk_panel_dark: assert property (
    st.ctrl[CTRL_LAMP_OFF] |=> lamps_o == 12'h000)
    else $error("panel not dark with lamps switched off");

  // With pulses disabled an idle pulse timer stays idle.
  chk_pulse_disabled: assert property (
    !st.ctrl[CTRL_PULSE_EN] && st.pulse_cnt == 32'h0 |=> st.pulse_cnt == 32'h0)
    else $error("fault pulse started while disabled");

  // Every valid management packet is flagged in the status register.
  chk_mgmt_status: assert property (
    mgmt_pkt_i |=> st.status[EV_MGMT_PKT])
    else $error("management packet not flagged");

  // A timed-out generator stays off until the selection returns to normal.
  chk_pg_no_restart: assert property (
    st.pg == PG_TIMED_OUT |=> !pattern_gen_on_o)
    else $error("pattern generator restarted after timeout");

endmodule // lsil_top

//--- hdl/lsil_pkg.sv
// Shared types, register map and timing constants for the front-panel lamp logic.
package lsil_pkg;

  // Clock rate and the printed times, each followed by its cycle count.
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned PG_TIMEOUT_S  = 45;
  localparam int unsigned PG_TIMEOUT_CYC = PG_TIMEOUT_S * CLK_HZ;
  localparam int unsigned RATE_BLINK_MS = 200;
  localparam int unsigned RATE_BLINK_CYC = RATE_BLINK_MS * CYC_PER_MS;
  localparam int unsigned MGMT_FLASH_MS = 400;
  localparam int unsigned MGMT_FLASH_CYC = MGMT_FLASH_MS * CYC_PER_MS;
  localparam int unsigned ERR_PULSE_MS  = 50;
  localparam int unsigned ERR_PULSE_CYC = ERR_PULSE_MS * CYC_PER_MS;

  // Register bus geometry and byte offsets.
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 32;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  REG_IRQ_MASK  = 4'h8;
  localparam logic [3:0]  REG_LAMPS     = 4'hC;

  // Event bit positions shared by the status and mask registers.
  localparam int unsigned EV_W          = 5;
  localparam int unsigned EV_CRC        = 0;
  localparam int unsigned EV_BIT_ERR    = 1;
  localparam int unsigned EV_PG_TIMEOUT = 2;
  localparam int unsigned EV_MGMT_PKT   = 3;
  localparam int unsigned EV_RATE_ERR   = 4;

  // Control register fields and reset values.
  localparam int unsigned CTRL_PULSE_EN = 0;
  localparam int unsigned CTRL_LAMP_OFF = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;
  localparam logic [4:0]  MASK_RESET    = 5'h00;

  typedef logic [31:0] lsil_cnt_t;

  // Lamp colour codes.
  typedef enum logic [1:0] {
    LAMP_OFF    = 2'h0,
    LAMP_GREEN  = 2'h1,
    LAMP_YELLOW = 2'h2,
    LAMP_RED    = 2'h3
  } lsil_lamp_e;

  // The six front-panel lamps travel together.
  typedef struct packed {
    lsil_lamp_e span_link_lamp;
    lsil_lamp_e transmit_line_lamp;
    lsil_lamp_e receive_line_lamp;
    lsil_lamp_e no_signal_lamp;
    lsil_lamp_e fault_lamp;
    lsil_lamp_e test_lamp;
  } lsil_lamps_s;

  // Pattern generator states, one-hot.
  typedef enum logic [2:0] {
    PG_IDLE      = 3'h1,
    PG_RUN       = 3'h2,
    PG_TIMED_OUT = 3'h4
  } lsil_pg_e;

endpackage

//--- verif/lsil_remote_model.sv
// Behavioural model of the remote modem at the far end of the span.
`timescale 1ns/10ps
module lsil_remote_model
#(
  parameter int LINK_DLY = 6
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic dial_i,
  input  wire logic rtest_i,
  input  wire logic pkt_i,
  output logic      link_up_o,
  output logic      connected_o,
  output logic      remote_test_o,
  output logic      mgmt_pkt_o
);
  int train_cnt;

  // Training takes LINK_DLY cycles, so the lamps see a slow far end rather than an instant one.
  // A remote test can only be requested once the two units are connected.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      train_cnt <= 0;
      link_up_o <= 1'b0;
      connected_o <= 1'b0;
      remote_test_o <= 1'b0;
      mgmt_pkt_o <= 1'b0;
    end else begin
      if (dial_i && train_cnt < LINK_DLY) begin
        train_cnt <= train_cnt + 1;
      end
      if (!dial_i) begin
        train_cnt <= 0;
      end
      link_up_o <= dial_i && (train_cnt == LINK_DLY);
      connected_o <= dial_i && (train_cnt == LINK_DLY);
      remote_test_o <= rtest_i && connected_o;
      mgmt_pkt_o <= pkt_i;
    end
  end
endmodule // lsil_remote_model

//--- verif/tb_lsil_top.sv
// Self-checking testbench for the front-panel lamp logic.
`timescale 1ns/10ps
module tb_lsil_top;
  import lsil_pkg::*;
  localparam int PG = 50;
  localparam int BL = 8;
  localparam int FL = 10;
  localparam int PU = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        tx = 1'b1;
  logic        rx = 1'b1;
  logic        loc = 1'b0;
  logic        sel = 1'b0;
  logic        crc = 1'b0;
  logic        berr = 1'b0;
  logic        rate = 1'b0;
  logic        strap = 1'b0;
  logic        dial = 1'b0;
  logic        rtest = 1'b0;
  logic        pkt = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  lsil_lamps_s lamps;
  logic        pg_on;
  logic        dte;
  logic        irq;
  logic        link_up;
  logic        conn;
  logic        r_test;
  logic        mgmt;
  logic [31:0] d;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          on_cnt = 0;
  int          c;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  lsil_remote_model #(.LINK_DLY(6)) i_far (
    .sys_clk_i(clk), .rst_b_i(rst_b), .dial_i(dial), .rtest_i(rtest), .pkt_i(pkt),
    .link_up_o(link_up), .connected_o(conn), .remote_test_o(r_test), .mgmt_pkt_o(mgmt));

  lsil_top #(.PG_CYC(PG), .BLINK_CYC(BL), .FLASH_CYC(FL), .PULSE_CYC(PU)) i_dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .span_link_up_i(link_up), .tx_data_i(tx),
    .rx_data_i(rx), .connected_i(conn), .local_test_i(loc), .remote_test_i(r_test),
    .pattern_sel_i(sel), .crc_err_i(crc), .bit_err_i(berr), .rate_unsupported_i(rate),
    .mgmt_pkt_i(mgmt), .dte_strap_i(strap), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .lamps_o(lamps),
    .pattern_gen_on_o(pg_on), .dte_role_o(dte), .irq_o(irq));

  // Cycle watchdog and run-time count of the pattern generator.
  always @(posedge clk) begin
    cyc++;
    if (pg_on === 1'b1) begin
      on_cnt++;
    end
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  // One-cycle event pulse: 0 CRC error, 1 bit error, 2 management packet.
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) begin
      crc <= 1'b1;
    end else if (k == 1) begin
      berr <= 1'b1;
    end else begin
      pkt <= 1'b1;
    end
    @(posedge clk);
    crc <= 1'b0;
    berr <= 1'b0;
    pkt <= 1'b0;
  endtask

  // Counts lit cycles over a window: 0 fault red, 1 test lamp not off.
  task automatic count(input int n, input int k, output int lit);
    lit = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (k == 0) lit += int'(lamps.fault_lamp === LAMP_RED);
      else lit += int'(lamps.test_lamp !== LAMP_OFF);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_CTRL, d);
    chk("ctrl reset", d, 32'h1);
    rd(REG_IRQ_MASK, d);
    chk("mask reset", d, 32'h0);
    rd(4'h2, d);
    chk("unmapped read", d, 32'h0);
    chk("dte role default", dte, 1'b0);
    chk("no signal red", lamps.no_signal_lamp, LAMP_RED);
    chk("span lamp off", lamps.span_link_lamp, LAMP_OFF);
    $display("test reset done");
    // Power-up rate error: continuous blink, single CRC pulse hidden in it.
    wr(REG_IRQ_MASK, 32'h1F);
    rate <= 1'b1;
    pulse(0);
    count(2 * BL, 0, c);
    chk("rate blink lit cycles", c, BL);
    chk("rate irq", irq, 1'b1);
    @(posedge clk);
    rate <= 1'b0;
    dial <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk("span lamp green", lamps.span_link_lamp, LAMP_GREEN);
    chk("no signal off", lamps.no_signal_lamp, LAMP_OFF);
    wr(REG_IRQ_STAT, 32'h1F);
    rd(REG_IRQ_STAT, d);
    chk("status cleared", d, 32'h0);
    chk("irq cleared", irq, 1'b0);
    $display("test power-up done");
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      tx <= v[0];
      rx <= !v[0];
      repeat (3) @(posedge clk);
      #1;
      chk("tx lamp", lamps.transmit_line_lamp, v ? LAMP_YELLOW : LAMP_GREEN);
      chk("rx lamp", lamps.receive_line_lamp, v ? LAMP_GREEN : LAMP_YELLOW);
    end
    pulse(0);
    count(PU + 6, 0, c);
    chk("crc pulse cycles", c, PU);
    rd(REG_IRQ_STAT, d);
    chk("crc status", d, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    #1;
    chk("irq after clear", irq, 1'b0);
    pulse(1);
    count(PU + 6, 0, c);
    chk("bit error outside test", c, 0);
    $display("test errors done");
    @(posedge clk);
    loc <= 1'b1;
    repeat (3) @(posedge clk);
    chk("local test lamp", lamps.test_lamp, LAMP_YELLOW);
    loc <= 1'b0;
    rtest <= 1'b1;
    repeat (4) @(posedge clk);
    chk("remote test lamp", lamps.test_lamp, LAMP_YELLOW);
    rtest <= 1'b0;
    repeat (4) @(posedge clk);
    chk("test lamp off", lamps.test_lamp, LAMP_OFF);
    pulse(2);
    count(FL + 6, 1, c);
    chk("packet flash cycles", c, FL);
    $display("test test-lamp done");
    // Pattern test: bit error flagged, CRC ignored, timeout blink until deselected.
    wr(REG_IRQ_STAT, 32'h1F);
    on_cnt = 0;
    sel <= 1'b1;
    pulse(1);
    count(PU + 6, 0, c);
    chk("bit error pulse", c, PU);
    pulse(0);
    count(PU + 4, 0, c);
    chk("crc during test", c, 0);
    repeat (PG) @(posedge clk);
    chk("generator run cycles", on_cnt, PG);
    pulse(0);
    count(2 * BL, 0, c);
    chk("timeout blink", c, BL);
    rd(REG_IRQ_STAT, d);
    chk("timeout status", d[EV_PG_TIMEOUT], 1'b1);
    @(posedge clk);
    sel <= 1'b0;
    repeat (3) @(posedge clk);
    count(2 * BL, 0, c);
    chk("blink stops", c, 0);
    $display("test pattern done");
    // Lamp snapshot register, then the lamps-off and pulse-enable control bits.
    rd(REG_LAMPS, d);
    chk("lamps register", d, 32'h8640);
    wr(REG_CTRL, 32'h2);
    pulse(0);
    repeat (2) @(posedge clk);
    chk("lamps dark", lamps, 32'h0);
    wr(REG_CTRL, 32'h1);
    count(PU + 4, 0, c);
    chk("pulse disabled", c, 0);
    $display("test control done");
    @(posedge clk);
    strap <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dte role strap", dte, 1'b1);
    $display("test strap done");
    final_report();
  end
endmodule // tb_lsil_top
